/* verilog/sppu_pkg.sv */
// Package of constants and types for the SRAM page pointer unit
package sppu_pkg;
	localparam int PAGE_W = 3;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int NUM_SEL = 5;
	// Word indices of the selectors (byte address is four times the index)
	localparam logic [ADDR_W-1:0] IDX_GENERAL = 8'hd0;
	localparam logic [ADDR_W-1:0] IDX_STACK = 8'hd1;
	localparam logic [ADDR_W-1:0] IDX_INDEXED = 8'hd3;
	localparam logic [ADDR_W-1:0] IDX_BLOCK_READ = 8'hd4;
	localparam logic [ADDR_W-1:0] IDX_BLOCK_WRITE = 8'hd5;
	localparam logic [PAGE_W-1:0] PAGE_RESET = 3'h0;
	localparam int SEL_GENERAL = 0;
	localparam int SEL_STACK = 1;
	localparam int SEL_INDEXED = 2;
	localparam int SEL_BLOCK_READ = 3;
	localparam int SEL_BLOCK_WRITE = 4;
	// Access class presented by the core's address logic
	typedef enum logic [2:0]
	{
		CLASS_GENERAL,
		CLASS_STACK,
		CLASS_INDEXED,
		CLASS_BLOCK_READ,
		CLASS_BLOCK_WRITE
	} sppu_class_type;
endpackage

/* verilog/sppu_sel_if.sv */
// Interface carrying the stored selectors and write strobes between modules
`timescale 1ns/1ps
interface sppu_sel_if;
	import sppu_pkg::*;
	logic [NUM_SEL-1:0] wr_en;
	logic [PAGE_W-1:0] wr_page;
	logic [NUM_SEL*PAGE_W-1:0] pages;
	modport ctrl (output wr_en, output wr_page, input pages);
	modport store (input wr_en, input wr_page, output pages);
endinterface

/* verilog/sppu_sel_bank.sv */
// Bank of page selector flip-flops, one entry per selector
`timescale 1ns/1ps
module sppu_sel_bank
(
	input wire logic ref_clk,
	input wire logic resetn,
	sppu_sel_if.store sel
);
	import sppu_pkg::*;
	typedef struct packed
	{
		logic [NUM_SEL*PAGE_W-1:0] pages;
	} sppu_bank_type;
	sppu_bank_type state_q;
	sppu_bank_type state_d;
	// Load the addressed entry on its strobe
	always_comb
	begin
		state_d = state_q;
		for (int i = 0; i < NUM_SEL; i++)
		begin
			if (sel.wr_en[i])
				state_d.pages[i*PAGE_W +: PAGE_W] = sel.wr_page;
		end
	end
	// Every entry clears to page zero at reset
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			state_q <= '{pages: {NUM_SEL{PAGE_RESET}}};
		else
			state_q <= state_d;
	end
	assign sel.pages = state_q.pages;
	// Each entry takes the written page one edge after its strobe
	for (genvar g = 0; g < NUM_SEL; g++)
	begin : g_load_chk
		bank_load_a: assert property (@(posedge ref_clk) disable iff (!resetn)
			sel.wr_en[g] |=> state_q.pages[g*PAGE_W +: PAGE_W] == $past(sel.wr_page))
			else $error("selector entry missed its write");
	end
endmodule

/* verilog/sppu_page_map.sv */
// Picks the page for one access class and applies the multi-page gate
`timescale 1ns/1ps
module sppu_page_map
(
	input wire logic [sppu_pkg::NUM_SEL*sppu_pkg::PAGE_W-1:0] pages,
	input wire sppu_pkg::sppu_class_type acc_class,
	input wire logic indexed_active,
	input wire logic multi_page,
	output logic [sppu_pkg::PAGE_W-1:0] page
);
	import sppu_pkg::*;
	logic [PAGE_W-1:0] pick;
	// Select the selector that serves the class
	always_comb
	begin
		pick = pages[SEL_GENERAL*PAGE_W +: PAGE_W];
		unique case (acc_class)
			CLASS_GENERAL: pick = pages[SEL_GENERAL*PAGE_W +: PAGE_W];
			CLASS_STACK: pick = pages[SEL_STACK*PAGE_W +: PAGE_W];
			CLASS_INDEXED:
			begin
				if (indexed_active)
					pick = pages[SEL_INDEXED*PAGE_W +: PAGE_W];
			end
			CLASS_BLOCK_READ: pick = pages[SEL_BLOCK_READ*PAGE_W +: PAGE_W];
			CLASS_BLOCK_WRITE: pick = pages[SEL_BLOCK_WRITE*PAGE_W +: PAGE_W];
			default: pick = pages[SEL_GENERAL*PAGE_W +: PAGE_W];
		endcase
	end
	// Single-page parts always see page zero; value is a plain binary page number
	assign page = multi_page ? pick : PAGE_RESET;
endmodule

/* verilog/sppu_top.sv */
// Top of the SRAM page pointer unit with its Wishbone register slave
// How it works
// - Ordinary data accesses use the general page selector field.
// - Stack accesses use the stack page selector field.
// - Indexed accesses use the indexed selector while it is active.
// - Indirect move reads use the block-read page selector.
// - Indirect move writes use the block-write page selector.
// - Each three-bit field is a binary page number, zero to seven.
// - Selectors only steer addresses when more than one page exists.
`timescale 1ns/1ps
module sppu_top
#(
	parameter int NUM_PAGES = 8
)
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [sppu_pkg::ADDR_W+1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [sppu_pkg::DATA_W-1:0] wb_dat_i,
	output logic [sppu_pkg::DATA_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire sppu_pkg::sppu_class_type acc_class,
	input wire logic indexed_active,
	output logic [sppu_pkg::PAGE_W-1:0] acc_page
);
	import sppu_pkg::*;
	// Page count must fit the three-bit field; refused at elaboration
	if (NUM_PAGES < 1 || NUM_PAGES > (1 << PAGE_W))
	begin : g_bad_pages
		$error("NUM_PAGES out of range");
	end
	localparam logic MULTI_PAGE = (NUM_PAGES > 1);
	// Word index of each selector slot, in slot order
	localparam logic [ADDR_W-1:0] SLOT_IDX [NUM_SEL] = '{IDX_GENERAL, IDX_STACK, IDX_INDEXED, IDX_BLOCK_READ,
		IDX_BLOCK_WRITE};
	typedef struct packed
	{
		logic ack;
		logic [DATA_W-1:0] rdata;
		logic [PAGE_W-1:0] page;
	} sppu_top_type;
	sppu_top_type state_q;
	sppu_top_type state_d;
	sppu_sel_if sel();
	logic [ADDR_W-1:0] word_idx;
	logic req;
	logic wr_req;
	logic rd_req;
	logic hit;
	int sel_idx;
	logic [PAGE_W-1:0] map_page;
	assign word_idx = wb_adr_i[ADDR_W+1:2];
	assign req = wb_cyc_i && wb_stb_i && !state_q.ack;
	// Taken writes and reads, watched by the checks below
	assign wr_req = req && wb_we_i;
	assign rd_req = req && !wb_we_i;
	// Decode the word index to a selector slot
	always_comb
	begin
		hit = 1'b1;
		sel_idx = SEL_GENERAL;
		unique case (word_idx)
			IDX_GENERAL: sel_idx = SEL_GENERAL;
			IDX_STACK: sel_idx = SEL_STACK;
			IDX_INDEXED: sel_idx = SEL_INDEXED;
			IDX_BLOCK_READ: sel_idx = SEL_BLOCK_READ;
			IDX_BLOCK_WRITE: sel_idx = SEL_BLOCK_WRITE;
			default: hit = 1'b0;
		endcase
	end
	// Write strobe for the addressed selector, low byte lane only; upper bits are dropped
	always_comb
	begin
		sel.wr_en = '0;
		if (req && wb_we_i && hit && wb_sel_i[0])
			sel.wr_en[sel_idx] = 1'b1;
	end
	assign sel.wr_page = wb_dat_i[PAGE_W-1:0];
	sppu_sel_bank u_bank
	(
		.ref_clk(ref_clk),
		.resetn(resetn),
		.sel(sel)
	);
	sppu_page_map u_map
	(
		.pages(sel.pages),
		.acc_class(acc_class),
		.indexed_active(indexed_active),
		.multi_page(MULTI_PAGE),
		.page(map_page)
	);
	// One-cycle ack; reads return the field, upper bits zero, unmapped reads zero
	always_comb
	begin
		state_d = state_q;
		state_d.ack = req;
		state_d.page = map_page;
		if (req && !wb_we_i)
		begin
			state_d.rdata = '0;
			if (hit)
				state_d.rdata[PAGE_W-1:0] = sel.pages[sel_idx*PAGE_W +: PAGE_W];
		end
	end
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			state_q <= '0;
		else
			state_q <= state_d;
	end
	assign wb_ack_o = state_q.ack;
	assign wb_dat_o = state_q.rdata;
	assign acc_page = state_q.page;
	// Request answered on the next edge
	bus_ack_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		req |=> wb_ack_o)
		else $error("request not acknowledged in one cycle");
	// No ack without a request the edge before
	ack_cause_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		!req |=> !wb_ack_o)
		else $error("ack without a request");
	// Ack never stands two cycles
	ack_single_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	// Read data upper bits stay zero
	rd_upper_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		wb_ack_o |-> wb_dat_o[DATA_W-1:PAGE_W] == '0)
		else $error("upper read bits not zero");
	// Read data stands until the next read
	rd_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		!rd_req |=> $stable(wb_dat_o))
		else $error("read data changed without a read");
	// Unmapped words read zero and store nothing
	rd_unmapped_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(rd_req && !hit) |=> wb_dat_o == '0)
		else $error("unmapped read not zero");
	wr_unmapped_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(wr_req && !hit) |=> $stable(sel.pages))
		else $error("unmapped write changed a selector");
	// Writes without the low byte lane store nothing
	lane_gate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(wr_req && !wb_sel_i[0]) |=> $stable(sel.pages))
		else $error("write without low lane changed a selector");
	// Per selector: a write lands, nothing else moves it, a read returns it
	for (genvar g = 0; g < NUM_SEL; g++)
	begin : g_slot_chk
		slot_write_a: assert property (@(posedge ref_clk) disable iff (!resetn)
			(wr_req && wb_sel_i[0] && word_idx == SLOT_IDX[g])
			|=> sel.pages[g*PAGE_W +: PAGE_W] == $past(wb_dat_i[PAGE_W-1:0]))
			else $error("selector write did not land");
		slot_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
			!(wr_req && wb_sel_i[0] && word_idx == SLOT_IDX[g]) |=> $stable(sel.pages[g*PAGE_W +: PAGE_W]))
			else $error("selector changed without its write");
		slot_read_a: assert property (@(posedge ref_clk) disable iff (!resetn)
			(rd_req && word_idx == SLOT_IDX[g]) |=> wb_dat_o == DATA_W'($past(sel.pages[g*PAGE_W +: PAGE_W])))
			else $error("selector read back wrong");
	end
	// Stack class follows its selector
	stack_page_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(acc_class == CLASS_STACK && MULTI_PAGE) |=> acc_page == $past(sel.pages[SEL_STACK*PAGE_W +: PAGE_W]))
		else $error("stack page wrong");
	// General class follows its selector
	gen_page_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(acc_class == CLASS_GENERAL && MULTI_PAGE) |=> acc_page == $past(sel.pages[SEL_GENERAL*PAGE_W +: PAGE_W]))
		else $error("general page wrong");
	// Active indexed class follows its selector
	idx_page_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(acc_class == CLASS_INDEXED && indexed_active && MULTI_PAGE)
		|=> acc_page == $past(sel.pages[SEL_INDEXED*PAGE_W +: PAGE_W]))
		else $error("indexed page wrong");
	// Inactive indexed class falls back to the general selector
	idx_fallback_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(acc_class == CLASS_INDEXED && !indexed_active && MULTI_PAGE)
		|=> acc_page == $past(sel.pages[SEL_GENERAL*PAGE_W +: PAGE_W]))
		else $error("inactive indexed page wrong");
	// Block read and write classes follow their selectors
	mvr_page_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(acc_class == CLASS_BLOCK_READ && MULTI_PAGE) |=> acc_page == $past(sel.pages[SEL_BLOCK_READ*PAGE_W +: PAGE_W]))
		else $error("block read page wrong");
	mvw_page_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(acc_class == CLASS_BLOCK_WRITE && MULTI_PAGE)
		|=> acc_page == $past(sel.pages[SEL_BLOCK_WRITE*PAGE_W +: PAGE_W]))
		else $error("block write page wrong");
	// Single-page parts see page zero
	single_page_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		!MULTI_PAGE |-> acc_page == PAGE_RESET)
		else $error("page used on single-page part");
endmodule

/* tb/sppu_core_model.sv */
// Core-side address logic model presenting access classes
`timescale 1ns/1ps
module sppu_core_model
(
	input wire logic ref_clk,
	input wire logic [sppu_pkg::PAGE_W-1:0] acc_page,
	output sppu_pkg::sppu_class_type acc_class,
	output logic indexed_active
);
	import sppu_pkg::*;
	// Idle on ordinary accesses
	initial
	begin
		acc_class = CLASS_GENERAL;
		indexed_active = 1'b0;
	end
	// One access; page is registered, so taken a cycle later
	task automatic access(input sppu_class_type c, input logic act, output logic [PAGE_W-1:0] pg);
		@(posedge ref_clk);
		acc_class <= c;
		indexed_active <= act;
		@(posedge ref_clk);
		#1 pg = acc_page;
	endtask
endmodule

/* tb/sppu_top_test.sv */
// Self-checking bench for the page pointer unit
`timescale 1ns/1ps
module sppu_top_test;
	import sppu_pkg::*;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [ADDR_W+1:0] adr = '0;
	logic [DATA_W-1:0] wdat = '0;
	logic [DATA_W-1:0] rdat;
	logic [DATA_W-1:0] rdat_one;
	logic [3:0] lanes = 4'hf;
	logic [3:0] bsel = 4'hf;
	logic [DATA_W-1:0] rd;
	logic ack;
	logic [PAGE_W-1:0] page;
	logic [PAGE_W-1:0] page_one;
	logic [PAGE_W-1:0] pg;
	sppu_class_type acc_class;
	logic indexed_active;
	int error_cnt = 0;
	int checked = 0;
	logic [ADDR_W-1:0] idx [NUM_SEL] = '{IDX_GENERAL, IDX_STACK, IDX_INDEXED, IDX_BLOCK_READ, IDX_BLOCK_WRITE};
	always #10 ref_clk = ~ref_clk;
	// Paged unit and a single-page unit on the same bus
	sppu_top u_sppu_top (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(bsel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.acc_class(acc_class), .indexed_active(indexed_active), .acc_page(page));
	sppu_top #(.NUM_PAGES(1)) u_sppu_top_one (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(bsel), .wb_dat_i(wdat), .wb_dat_o(rdat_one),
		.wb_ack_o(), .acc_class(acc_class), .indexed_active(indexed_active), .acc_page(page_one));
	sppu_core_model u_sppu_core_model (.ref_clk(ref_clk), .acc_page(page), .acc_class(acc_class),
		.indexed_active(indexed_active));
	// Verdict and end of run
	task automatic complete_run();
		if (error_cnt == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Compare and count
	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	// Classic single Wishbone cycle, held until ack
	task automatic wb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		output logic [DATA_W-1:0] r);
		int n;
		n = 0;
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {a, 2'b00};
		wdat <= d;
		bsel <= lanes;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1)
		begin
			error_cnt++;
			complete_run();
		end
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	// Main sequence
	initial
	begin
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		for (int i = 0; i < NUM_SEL; i++)
		begin
			wb(1'b0, idx[i], '0, rd);
			check(rd, 32'h0);
			wb(1'b1, idx[i], 32'(i + 3), rd);
		end
		for (int i = 0; i < NUM_SEL; i++)
		begin
			wb(1'b0, idx[i], '0, rd);
			check(rd, 32'(i + 3));
			check(rdat_one, 32'(i + 3));
			u_sppu_core_model.access(sppu_class_type'(i), 1'b1, pg);
			check(32'(pg), 32'(i + 3));
			check(32'(page_one), 32'h0);
		end
		u_sppu_core_model.access(CLASS_INDEXED, 1'b0, pg);
		check(32'(pg), 32'h3);
		// Every page number on the ordinary selector
		for (int p = 0; p < 8; p++)
		begin
			wb(1'b1, IDX_GENERAL, 32'(p), rd);
			u_sppu_core_model.access(CLASS_GENERAL, 1'b0, pg);
			check(32'(pg), 32'(p));
		end
		// Unmapped word between stack and indexed
		wb(1'b1, 8'hd2, 32'h5, rd);
		wb(1'b0, 8'hd2, '0, rd);
		check(rd, 32'h0);
		wb(1'b0, IDX_STACK, '0, rd);
		check(rd, 32'h4);
		// Write without the low byte lane is ignored
		lanes = 4'he;
		wb(1'b1, IDX_STACK, 32'h1, rd);
		lanes = 4'hf;
		wb(1'b0, IDX_STACK, '0, rd);
		check(rd, 32'h4);
		// Reset in mid-run clears the selectors
		@(posedge ref_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		wb(1'b0, IDX_BLOCK_WRITE, '0, rd);
		check(rd, 32'h0);
		wb(1'b0, IDX_GENERAL, '0, rd);
		check(rd, 32'h0);
		u_sppu_core_model.access(CLASS_BLOCK_WRITE, 1'b0, pg);
		check(32'(pg), 32'h0);
		complete_run();
	end
endmodule
